/* bls_pkg.sv */
// Constants, register map and state type shared by the linear scaler design.
//
// Summary of operation
// RL1 - Binary-to-BCD error: zero horizontal or non-BCD vertical slope
// RL2 - Equals flag set when result is zero
// RL3 - Binary-to-BCD carry flag carries result sign
// RL4 - Binary-to-BCD: vertical/horizontal slope times (source minus offset)
// RL5 - Binary-to-BCD block: offset, horizontal, vertical slope
// RL6 - Quotient rounded to nearest integer
// RL7 - Binary-to-BCD result saturates at plus/minus 9999
// RL8 - Offsets and slopes may be negative; the code takes the BCD slope (B2D vertical, D2B horizontal) as unsigned
// RL9 - BCD-to-binary error: bad source or horizontal slope
// RL10 - Negative flag copies result most significant bit
// RL11 - BCD-to-binary: vertical/horizontal slope times (source plus offset)
// RL12 - BCD source magnitude signed by carry flag
// RL13 - BCD-to-binary result clamped to minimum and maximum
// RL14 - BCD-to-binary block holds five consecutive words
// RL15 - Halfway quotients round away from zero
package bls_pkg;

  // ---------------------------------------------------------------------------
  // Bus and word sizes
  // ---------------------------------------------------------------------------
  localparam int BLS_ADDR_W = 8;
  localparam int BLS_WORD_W = 16;

  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] BLS_CTRL_OFS     = 8'h00;
  localparam logic [7:0] BLS_SOURCE_OFS   = 8'h04;
  localparam logic [7:0] BLS_FLAGS_OFS    = 8'h08;
  localparam logic [7:0] BLS_RESULT_OFS   = 8'h0C;
  localparam logic [7:0] BLS_BASE_OFS     = 8'h10;
  localparam logic [7:0] BLS_IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] BLS_IRQ_CLR_OFS  = 8'h18;
  localparam logic [7:0] BLS_IRQ_EN_OFS   = 8'h1C;
  localparam logic [1:0] BLS_PARAM_SEL    = 2'h1;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int BLS_CTRL_START_BIT = 0;
  localparam int BLS_CTRL_OP_BIT    = 1;
  localparam int BLS_FLG_ERR_BIT    = 0;
  localparam int BLS_FLG_EQ_BIT     = 1;
  localparam int BLS_FLG_CY_BIT     = 2;
  localparam int BLS_FLG_NEG_BIT    = 3;
  localparam int BLS_FLG_BUSY_BIT   = 4;
  localparam int BLS_IRQ_DONE_BIT   = 0;
  localparam int BLS_IRQ_ERR_BIT    = 1;
  localparam int BLS_IRQ_W          = 2;

  // ---------------------------------------------------------------------------
  // Parameter block layout, word index from the parameter base word
  // ---------------------------------------------------------------------------
  localparam logic [2:0] BLS_B2D_WORDS      = 3'h3;
  localparam int         BLS_B2D_OFFSET_IDX = 0;
  localparam int         BLS_B2D_HSLOPE_IDX = 1;
  localparam int         BLS_B2D_VSLOPE_IDX = 2;
  localparam logic [2:0] BLS_D2B_WORDS      = 3'h5;
  localparam int         BLS_D2B_HSLOPE_IDX = 0;
  localparam int         BLS_D2B_VSLOPE_IDX = 1;
  localparam int         BLS_D2B_OFFSET_IDX = 2;
  localparam int         BLS_D2B_MAX_IDX    = 3;
  localparam int         BLS_D2B_MIN_IDX    = 4;
  localparam int         BLS_MAX_WORDS      = 5;

  // ---------------------------------------------------------------------------
  // Values, reset values and counts
  // ---------------------------------------------------------------------------
  localparam logic [13:0] BLS_BCD_MAX_BIN = 14'h270F;
  localparam logic [15:0] BLS_WORD_RESET  = 16'h0000;
  localparam logic [5:0]  BLS_DIV_LAST    = 6'h1F;
  localparam logic        BLS_OP_B2D      = 1'b0;
  localparam logic        BLS_OP_D2B      = 1'b1;

  typedef enum logic [4:0] {
    BLS_IDLE  = 5'b00001,
    BLS_FETCH = 5'b00010,
    BLS_CALC  = 5'b00100,
    BLS_DIV   = 5'b01000,
    BLS_DONE  = 5'b10000
  } bls_state_t;

endpackage

/* bls_param_ram.sv */
// Parameter word memory with one write port and one registered read port.
`timescale 1ns/10ps
module bls_param_ram #(
  parameter int WORD_W = 16,
  parameter int DEPTH  = 16,
  parameter int AW     = 4
) (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  // Write port
  input  wire logic              wr_en_in,
  input  wire logic [AW-1:0]     wr_addr_in,
  input  wire logic [WORD_W-1:0] wr_data_in,
  // Read port
  input  wire logic [AW-1:0]     rd_addr_in,
  output logic      [WORD_W-1:0] rd_data_out
);

  logic [WORD_W-1:0] mem [0:DEPTH-1];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // bls_param_ram

/* bls_scaler.sv */
// Linear scaler between signed binary and sign-magnitude BCD, with APB registers.
`timescale 1ns/10ps
module bls_scaler
  import bls_pkg::*;
#(
  parameter int PARAM_DEPTH = 16,
  parameter int PARAM_AW    = 4
) (
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  reset_in,
  // APB slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [BLS_ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Interrupt
  output logic                       irq_out
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  bls_state_t        state_q;
  logic              op_q;
  logic [2:0]        fetch_cnt_q;
  logic [15:0]       word_q [0:BLS_MAX_WORDS-1];
  logic [15:0]       source_q;
  logic [15:0]       result_q;
  logic [PARAM_AW-1:0] parameter_base_word_q;
  logic              error_flag_q;
  logic              equals_flag_q;
  logic              carry_sign_flag_q;
  logic              negative_flag_q;
  logic [31:0]       num_q;
  logic [15:0]       den_q;
  logic [15:0]       rem_q;
  logic              neg_q;
  logic              err_q;
  logic [5:0]        div_cnt_q;
  logic [BLS_IRQ_W-1:0] irq_stat_q;
  logic [BLS_IRQ_W-1:0] irq_en_q;
  logic              irq_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;

  logic              busy;
  logic              access;
  logic              wr_ok;
  logic              is_param;
  logic              start;
  logic [2:0]        blk_size;
  logic [15:0]       ram_rdata;
  logic [PARAM_AW-1:0] ram_raddr;
  logic [31:0]       rd_val;
  logic              dec_err;
  logic [BLS_IRQ_W-1:0] irq_set;
  logic [BLS_IRQ_W-1:0] irq_clr;

  // ---------------------------------------------------------------------------
  // Arithmetic helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_bcd(input logic [15:0] w);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (w[4*i +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] w);
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 3; i >= 0; i--) begin
      v = 16'(v * 16'h000A) + {12'h000, w[4*i +: 4]};
    end
    return v;
  endfunction

  // Shift-and-add-three conversion; the input never exceeds 9999.
  function automatic logic [15:0] bin_to_bcd(input logic [13:0] b);
    logic [29:0] sh;
    sh = {16'h0000, b};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (sh[14+4*d +: 4] > 4'h4) begin
          sh[14+4*d +: 4] = sh[14+4*d +: 4] + 4'h3;
        end
      end
      sh = {sh[28:0], 1'b0};
    end
    return sh[29:14];
  endfunction

  // ---------------------------------------------------------------------------
  // Parameter memory
  // ---------------------------------------------------------------------------
  assign busy     = (state_q != BLS_IDLE);
  assign blk_size = (op_q == BLS_OP_D2B) ? BLS_D2B_WORDS : BLS_B2D_WORDS; // [RL5] [RL14]
  // The engine owns the read port while busy, so bus reads of the memory are refused then.
  assign ram_raddr = busy ? (parameter_base_word_q + PARAM_AW'(fetch_cnt_q))
                          : paddr_in[2 +: PARAM_AW];

  bls_param_ram #(
    .WORD_W (BLS_WORD_W),
    .DEPTH  (PARAM_DEPTH),
    .AW     (PARAM_AW)
  ) u_param_ram (
    .clk_in      (clk_in),
    .reset_in    (reset_in),
    .wr_en_in    (wr_ok && is_param),
    .wr_addr_in  (paddr_in[2 +: PARAM_AW]),
    .wr_data_in  (pwdata_in[15:0]),
    .rd_addr_in  (ram_raddr),
    .rd_data_out (ram_rdata)
  );

  // ---------------------------------------------------------------------------
  // Operand setup: numerator and divisor magnitudes and result sign
  // ---------------------------------------------------------------------------
  logic [16:0] d_diff;
  logic [16:0] d_diff_mag;
  logic [15:0] d_dx_mag;
  logic [15:0] d_dy;
  logic [15:0] b_src;
  logic [17:0] b_sum;
  logic [16:0] b_sum_mag;
  logic [15:0] b_dy_mag;
  logic [31:0] calc_num;
  logic [15:0] calc_den;
  logic        calc_neg;
  logic        calc_err;

  always_comb begin
    d_diff     = {source_q[15], source_q}
               - {word_q[BLS_B2D_OFFSET_IDX][15], word_q[BLS_B2D_OFFSET_IDX]}; // [RL4] [RL8]
    d_diff_mag = d_diff[16] ? -d_diff : d_diff;
    d_dx_mag   = word_q[BLS_B2D_HSLOPE_IDX][15] ? -word_q[BLS_B2D_HSLOPE_IDX]
                                                : word_q[BLS_B2D_HSLOPE_IDX];
    d_dy       = bcd_to_bin(word_q[BLS_B2D_VSLOPE_IDX]);
    b_src      = bcd_to_bin(source_q);
    b_sum      = (carry_sign_flag_q ? -{2'b00, b_src} : {2'b00, b_src})
               + {{2{word_q[BLS_D2B_OFFSET_IDX][15]}}, word_q[BLS_D2B_OFFSET_IDX]}; // [RL11] [RL12]
    b_sum_mag  = b_sum[17] ? 17'(-b_sum) : b_sum[16:0];
    b_dy_mag   = word_q[BLS_D2B_VSLOPE_IDX][15] ? -word_q[BLS_D2B_VSLOPE_IDX]
                                                : word_q[BLS_D2B_VSLOPE_IDX];
    if (op_q == BLS_OP_B2D) begin
      calc_num = {16'h0000, d_dy} * {15'h0000, d_diff_mag}; // [RL4]
      calc_den = d_dx_mag;
      calc_neg = d_diff[16] ^ word_q[BLS_B2D_HSLOPE_IDX][15]; // [RL8]
      calc_err = (word_q[BLS_B2D_HSLOPE_IDX] == 16'h0000)
              || !is_bcd(word_q[BLS_B2D_VSLOPE_IDX]); // [RL1]
    end else begin
      calc_num = {15'h0000, b_sum_mag} * {16'h0000, b_dy_mag}; // [RL11]
      calc_den = bcd_to_bin(word_q[BLS_D2B_HSLOPE_IDX]);
      calc_neg = b_sum[17] ^ word_q[BLS_D2B_VSLOPE_IDX][15]; // [RL8]
      calc_err = !is_bcd(source_q) || !is_bcd(word_q[BLS_D2B_HSLOPE_IDX])
              || (word_q[BLS_D2B_HSLOPE_IDX] == 16'h0000); // [RL9]
    end
  end

  // ---------------------------------------------------------------------------
  // Rounding, saturation and clamping of the quotient
  // ---------------------------------------------------------------------------
  logic [16:0] rem_w;
  logic        rem_ge;
  logic        round_up;
  logic [31:0] q_round;
  logic [13:0] sat_mag;
  logic [32:0] d2b_val;
  logic [32:0] d2b_min;
  logic [32:0] d2b_max;
  logic [15:0] d2b_res;

  always_comb begin
    rem_w    = {rem_q, num_q[31]};
    rem_ge   = (rem_w >= {1'b0, den_q});
    // Twice the remainder against the divisor rounds ties away from zero in magnitude.
    round_up = ({rem_q, 1'b0} >= {1'b0, den_q}); // [RL6] [RL15]
    q_round  = num_q + {31'h0, round_up}; // [RL6]
    sat_mag  = (q_round > {18'h0, BLS_BCD_MAX_BIN}) ? BLS_BCD_MAX_BIN : q_round[13:0]; // [RL7]
    d2b_val  = neg_q ? -{1'b0, q_round} : {1'b0, q_round};
    d2b_min  = {{17{word_q[BLS_D2B_MIN_IDX][15]}}, word_q[BLS_D2B_MIN_IDX]};
    d2b_max  = {{17{word_q[BLS_D2B_MAX_IDX][15]}}, word_q[BLS_D2B_MAX_IDX]};
    if ($signed(d2b_val) < $signed(d2b_min)) begin
      d2b_res = word_q[BLS_D2B_MIN_IDX]; // [RL13]
    end else if ($signed(d2b_val) > $signed(d2b_max)) begin
      d2b_res = word_q[BLS_D2B_MAX_IDX]; // [RL13]
    end else begin
      d2b_res = d2b_val[15:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_q <= BLS_IDLE;
    end else begin
      case (state_q)
        BLS_IDLE: begin
          if (start) begin
            state_q <= BLS_FETCH;
          end
        end
        BLS_FETCH: begin
          if (fetch_cnt_q == blk_size) begin
            state_q <= BLS_CALC;
          end
        end
        BLS_CALC: begin
          state_q <= calc_err ? BLS_DONE : BLS_DIV;
        end
        BLS_DIV: begin
          if (div_cnt_q == BLS_DIV_LAST) begin
            state_q <= BLS_DONE;
          end
        end
        BLS_DONE: begin
          state_q <= BLS_IDLE;
        end
        default: begin
          state_q <= BLS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      op_q <= BLS_OP_B2D;
    end else if (start) begin
      op_q <= pwdata_in[BLS_CTRL_OP_BIT];
    end
  end

  // Read data lags the address by one cycle, so word k lands while address k+1 goes out.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      fetch_cnt_q <= 3'h0;
    end else if (state_q == BLS_FETCH) begin
      fetch_cnt_q <= fetch_cnt_q + 3'h1;
      if (fetch_cnt_q != 3'h0) begin
        word_q[3'(fetch_cnt_q - 3'h1)] <= ram_rdata; // [RL5] [RL14]
      end
    end else begin
      fetch_cnt_q <= 3'h0;
    end
  end

  // Restoring divider: one quotient bit per cycle, quotient shifts into num_q.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      num_q     <= 32'h0000_0000;
      den_q     <= 16'h0000;
      rem_q     <= 16'h0000;
      neg_q     <= 1'b0;
      err_q     <= 1'b0;
      div_cnt_q <= 6'h00;
    end else if (state_q == BLS_CALC) begin
      num_q     <= calc_num;
      den_q     <= calc_den;
      rem_q     <= 16'h0000;
      neg_q     <= calc_neg;
      err_q     <= calc_err;
      div_cnt_q <= 6'h00;
    end else if (state_q == BLS_DIV) begin
      rem_q     <= rem_ge ? 16'(rem_w - {1'b0, den_q}) : rem_w[15:0];
      num_q     <= {num_q[30:0], rem_ge};
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // Result and condition flags
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      result_q <= BLS_WORD_RESET;
    end else if (state_q == BLS_DONE && !err_q) begin
      result_q <= (op_q == BLS_OP_B2D) ? bin_to_bcd(sat_mag) : d2b_res; // [RL7] [RL11]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      error_flag_q <= 1'b0;
    end else if (state_q == BLS_DONE) begin
      error_flag_q <= err_q; // [RL1] [RL9]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      equals_flag_q <= 1'b0;
    end else if (state_q == BLS_DONE && !err_q) begin
      equals_flag_q <= (op_q == BLS_OP_B2D) ? (sat_mag == 14'h0000)
                                            : (d2b_res == 16'h0000); // [RL2]
    end
  end

  // Software may set or clear the sign before a BCD-to-binary run; the engine's update wins.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      carry_sign_flag_q <= 1'b0;
    end else if (state_q == BLS_DONE && !err_q && op_q == BLS_OP_B2D) begin
      carry_sign_flag_q <= neg_q && (sat_mag != 14'h0000); // [RL3]
    end else if (wr_ok && paddr_in == BLS_FLAGS_OFS) begin
      carry_sign_flag_q <= pwdata_in[BLS_FLG_CY_BIT]; // [RL12]
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      negative_flag_q <= 1'b0;
    end else if (state_q == BLS_DONE && !err_q && op_q == BLS_OP_D2B) begin
      negative_flag_q <= d2b_res[15]; // [RL10]
    end
  end

  // ---------------------------------------------------------------------------
  // APB register file
  // ---------------------------------------------------------------------------
  assign access   = psel_in && penable_in;
  assign wr_ok    = access && pready_q && pwrite_in && !pslverr_q;
  assign is_param = (paddr_in[7:6] == BLS_PARAM_SEL) && (paddr_in[1:0] == 2'b00);
  assign start    = wr_ok && (paddr_in == BLS_CTRL_OFS) && !busy
                 && pwdata_in[BLS_CTRL_START_BIT];

  always_comb begin
    rd_val  = 32'h0000_0000;
    dec_err = 1'b0;
    if (is_param) begin
      rd_val[15:0] = ram_rdata;
      dec_err      = busy;
    end else begin
      case (paddr_in)
        BLS_CTRL_OFS: begin
          rd_val[BLS_CTRL_OP_BIT] = op_q;
        end
        BLS_SOURCE_OFS: begin
          rd_val[15:0] = source_q;
        end
        BLS_FLAGS_OFS: begin
          rd_val[BLS_FLG_ERR_BIT]  = error_flag_q;
          rd_val[BLS_FLG_EQ_BIT]   = equals_flag_q;
          rd_val[BLS_FLG_CY_BIT]   = carry_sign_flag_q;
          rd_val[BLS_FLG_NEG_BIT]  = negative_flag_q;
          rd_val[BLS_FLG_BUSY_BIT] = busy;
        end
        BLS_RESULT_OFS: begin
          rd_val[15:0] = result_q;
        end
        BLS_BASE_OFS: begin
          rd_val[PARAM_AW-1:0] = parameter_base_word_q;
        end
        BLS_IRQ_STAT_OFS: begin
          rd_val[BLS_IRQ_W-1:0] = irq_stat_q;
        end
        BLS_IRQ_CLR_OFS: begin
          rd_val = 32'h0000_0000;
        end
        BLS_IRQ_EN_OFS: begin
          rd_val[BLS_IRQ_W-1:0] = irq_en_q;
        end
        default: begin
          dec_err = 1'b1;
        end
      endcase
    end
  end

  // Every transfer gets exactly one wait state; the answer is decided in the first access cycle.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (access && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= dec_err;
      prdata_q  <= pwrite_in ? 32'h0000_0000 : rd_val;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      source_q <= BLS_WORD_RESET;
    end else if (wr_ok && paddr_in == BLS_SOURCE_OFS) begin
      source_q <= pwdata_in[15:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      parameter_base_word_q <= '0;
    end else if (wr_ok && paddr_in == BLS_BASE_OFS && !busy) begin
      parameter_base_word_q <= pwdata_in[PARAM_AW-1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    irq_clr = '0;
    irq_set[BLS_IRQ_DONE_BIT] = (state_q == BLS_DONE);
    irq_set[BLS_IRQ_ERR_BIT]  = (state_q == BLS_DONE) && err_q;
    if (wr_ok && paddr_in == BLS_IRQ_CLR_OFS) begin
      irq_clr = pwdata_in[BLS_IRQ_W-1:0];
    end
  end

  // A completion in the same cycle as its clear stays pending.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_en_q <= '0;
    end else if (wr_ok && paddr_in == BLS_IRQ_EN_OFS) begin
      irq_en_q <= pwdata_in[BLS_IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign prdata_out  = prdata_q;
  assign pready_out  = pready_q;
  assign pslverr_out = pslverr_q;
  assign irq_out     = irq_q;

endmodule // bls_scaler

/* bls_scaler_properties.sv */
// Checker of the scaler's bus handshake and interrupt output.
`timescale 1ns/10ps
module bls_scaler_props
  import bls_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_in,
  input wire logic                  reset_in,
  // Bus and interrupt
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [BLS_ADDR_W-1:0] paddr_in,
  input wire logic [31:0]           pwdata_in,
  input wire logic [31:0]           prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  input wire logic                  irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_reset_quiet: assert property ($fell(reset_in) |-> !pready_out && !irq_out && prdata_out == 0)
    else $error("outputs not idle after reset");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_one_wait: assert property (psel_in && !penable_in ##1 psel_in && penable_in
    |-> !pready_out ##1 pready_out) else $error("ready not after one wait state");
  a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside access phase");
  a_err_with_ready: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_unmapped_err: assert property (psel_in && penable_in && !pready_out && paddr_in == 8'h20
    |=> pslverr_out) else $error("unmapped access not refused");
  a_mapped_read_ok: assert property (psel_in && penable_in && !pready_out && !pwrite_in
    && paddr_in < 8'h20 && paddr_in[1:0] == 2'h0 |=> !pslverr_out) else $error("read refused");
  a_rdata_hold: assert property (!pready_out && !$past(reset_in) |-> $stable(prdata_out))
    else $error("read data moved between transfers");
  a_irq_cleared: assert property (pready_out && pwrite_in && paddr_in == BLS_IRQ_CLR_OFS
    && pwdata_in[1:0] == 2'h3 |-> ##2 !irq_out) else $error("interrupt not cleared");
  a_irq_masked: assert property (pready_out && pwrite_in && paddr_in == BLS_IRQ_EN_OFS
    && pwdata_in[1:0] == 2'h0 |-> ##2 !irq_out) else $error("interrupt not masked");

  c_refused: cover property (pready_out && pslverr_out);
  c_irq: cover property ($rose(irq_out));
  c_write: cover property (pready_out && pwrite_in);
endmodule // bls_scaler_props

bind bls_scaler bls_scaler_props bls_scaler_props_i (.clk_in, .reset_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
  .irq_out);

/* tb_top.sv */
// Self-checking bench for the linear scaler, driven over its register bus.
`timescale 1ns/10ps
module tb_top;
  import bls_pkg::*;
  logic        clk_in     = 1'b0;
  logic        reset_in   = 1'b1;
  logic        psel_in    = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in  = 1'b0;
  logic [7:0]  paddr_in   = 8'h00;
  logic [31:0] pwdata_in  = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        irq_out;
  logic [31:0] rdat;
  logic        rerr;
  int          mismatches = 0;
  int          cmp_count  = 0;

  always #10 clk_in = ~clk_in;

  bls_scaler bls_scaler_i (.clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out);

  // ---------------------------------------------------------------------------
  // Bus tasks and comparison
  // ---------------------------------------------------------------------------
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // The leading edge keeps a release and the next setup out of one time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    rdat = prdata_out;
    rerr = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic ld(input logic [3:0] b, input logic [15:0] w0, w1, w2,
                    w3 = 16'h7FFF, w4 = 16'h8000);
    logic [15:0] w [5];
    logic [3:0]  ix;
    w = '{w0, w1, w2, w3, w4};
    apb(1'b1, BLS_BASE_OFS, {28'h0, b});
    for (int i = 0; i < 5; i++) begin
      ix = b + 4'(i);
      apb(1'b1, {2'b01, ix, 2'b00}, {16'h0, w[i]});
    end
  endtask

  // Flags are compared under a mask because each operation leaves some flags alone.
  task automatic run(input logic op, cy, input logic [15:0] s, r, input logic [3:0] fm, fe);
    int n;
    apb(1'b1, BLS_FLAGS_OFS, {29'h0, cy, 2'h0});
    apb(1'b1, BLS_SOURCE_OFS, {16'h0, s});
    apb(1'b1, BLS_CTRL_OFS, {30'h0, op, 1'b1});
    n = 0;
    do begin
      apb(1'b0, BLS_FLAGS_OFS, 32'h0);
      n++;
    end while (rdat[BLS_FLG_BUSY_BIT] !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      close_out();
    end
    chk("flags", {28'h0, fe}, rdat & {28'h0, fm});
    apb(1'b0, BLS_RESULT_OFS, 32'h0);
    chk("result", {16'h0, r}, rdat);
  endtask

  task automatic irqchk(input logic exp);
    repeat (2) @(posedge clk_in);
    chk("irq", {31'h0, exp}, {31'h0, irq_out});
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int a = 0; a < 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, rdat);
      chk("pslverr", 32'h0, {31'h0, rerr});
    end
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    apb(1'b0, 8'h02, 32'h0);
    chk("pslverr", 32'h1, {31'h0, rerr});
    $display("test registers done");
    ld(4'h0, 16'h0000, 16'h1770, 16'h0300);
    run(1'b0, 1'b0, 16'h0BB8, 16'h0150, 4'hF, 4'h0);
    ld(4'h0, 16'h07D0, 16'h1770, 16'h0400);
    run(1'b0, 1'b0, 16'h0000, 16'h0133, 4'hF, 4'h4);
    ld(4'hF, 16'h0000, 16'h0002, 16'h0001);
    run(1'b0, 1'b0, 16'hFFFD, 16'h0002, 4'hF, 4'h4);
    ld(4'h0, 16'h0000, 16'hFFFE, 16'h0001);
    run(1'b0, 1'b0, 16'h0005, 16'h0003, 4'hF, 4'h4);
    ld(4'h0, 16'h0000, 16'h0001, 16'h9999);
    run(1'b0, 1'b0, 16'h0002, 16'h9999, 4'hF, 4'h0);
    run(1'b0, 1'b0, 16'hFFFE, 16'h9999, 4'hF, 4'h4);
    run(1'b0, 1'b0, 16'h0000, 16'h0000, 4'hF, 4'h2);
    ld(4'h0, 16'h0000, 16'h0000, 16'h0001);
    run(1'b0, 1'b0, 16'h0001, 16'h0000, 4'h1, 4'h1);
    ld(4'h0, 16'h0000, 16'h0001, 16'h00A0);
    run(1'b0, 1'b0, 16'h0001, 16'h0000, 4'h1, 4'h1);
    $display("test binary to bcd done");
    ld(4'h0, 16'h0200, 16'h1770, 16'h0000);
    run(1'b1, 1'b0, 16'h0100, 16'h0BB8, 4'hB, 4'h0);
    run(1'b1, 1'b1, 16'h0100, 16'hF448, 4'hB, 4'h8);
    ld(4'h0, 16'h0200, 16'h1770, 16'h0032, 16'h0FA0, 16'hF060);
    run(1'b1, 1'b0, 16'h0100, 16'h0FA0, 4'hB, 4'h0);
    run(1'b1, 1'b1, 16'h0100, 16'hFA24, 4'hB, 4'h8);
    run(1'b1, 1'b1, 16'h0200, 16'hF060, 4'hB, 4'h8);
    ld(4'h0, 16'h0003, 16'h0001, 16'h0000);
    run(1'b1, 1'b0, 16'h0002, 16'h0001, 4'hB, 4'h0);
    run(1'b1, 1'b0, 16'h0001, 16'h0000, 4'hB, 4'h2);
    run(1'b1, 1'b0, 16'h00A0, 16'h0000, 4'h1, 4'h1);
    ld(4'h0, 16'h0000, 16'h0001, 16'h0000);
    run(1'b1, 1'b0, 16'h0001, 16'h0000, 4'h1, 4'h1);
    $display("test bcd to binary done");
    apb(1'b0, BLS_IRQ_STAT_OFS, 32'h0);
    chk("irq status", 32'h3, rdat);
    irqchk(1'b0);
    apb(1'b1, BLS_IRQ_CLR_OFS, 32'h3);
    apb(1'b0, BLS_IRQ_STAT_OFS, 32'h0);
    chk("irq status", 32'h0, rdat);
    apb(1'b1, BLS_IRQ_EN_OFS, 32'h2);
    run(1'b1, 1'b0, 16'h0001, 16'h0000, 4'h1, 4'h1);
    irqchk(1'b1);
    apb(1'b1, BLS_IRQ_EN_OFS, 32'h0);
    irqchk(1'b0);
    apb(1'b1, BLS_IRQ_EN_OFS, 32'h3);
    irqchk(1'b1);
    apb(1'b1, BLS_IRQ_CLR_OFS, 32'h3);
    irqchk(1'b0);
    $display("test interrupt done");
    close_out();
  end
endmodule // tb_top
